// [logic/boiex_pkg.sv]
// Constants shared by the byte operation execute block.
// Assumes a 12-bit instruction word and an 8-bit data path.
package boiex_pkg;
	localparam int INSN_W = 12;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 5;
	localparam int PC_W = 11;
	// Instruction field positions
	localparam int DEST_BIT = 5;
	localparam int JUMP_K_W = 9;
	// Status bits feeding the upper program counter bits on a jump
	localparam int PAGE_LO = 5;
	localparam int PAGE_HI = 6;
	// Opcode patterns, upper six bits for file forms
	localparam logic [5:0] OP_COMPLEMENT = 6'h09;
	localparam logic [5:0] OP_DECREMENT = 6'h03;
	localparam logic [5:0] OP_DEC_SKIP = 6'h0b;
	localparam logic [5:0] OP_INCREMENT = 6'h0a;
	localparam logic [5:0] OP_INC_SKIP = 6'h0f;
	localparam logic [5:0] OP_OR_FILE = 6'h04;
	localparam logic [5:0] OP_MOVE_FILE = 6'h08;
	localparam logic [5:0] OP_ROT_LEFT = 6'h0d;
	localparam logic [5:0] OP_ROT_RIGHT = 6'h0c;
	localparam logic [6:0] OP_STORE_ACC = 7'h01;
	localparam logic [2:0] OP_JUMP = 3'h5;
	localparam logic [3:0] OP_OR_LIT = 4'hd;
	localparam logic [3:0] OP_LOAD_LIT = 4'hc;
	localparam logic [3:0] OP_RET_LIT = 4'h8;
	localparam logic [11:0] OP_IDLE = 12'h000;
	localparam logic [11:0] OP_PRESCALE = 12'h002;
	// Reset values
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'hff;
	localparam logic [10:0] PC_RST = 11'h7ff;
endpackage

// [logic/boiex_alu.sv]
// Combinational result unit for the file and literal operations.
// Assumes the caller has already decoded the operation class.
`timescale 1ns/1ps
module boiex_alu
	import boiex_pkg::*;
(
	input wire logic [3:0] sel,
	input wire logic [7:0] fval,
	input wire logic [7:0] acc,
	input wire logic [7:0] lit,
	input wire logic carry_in,
	output logic [7:0] result,
	output logic carry_out
);
	// Result select per operation class
	always_comb
	begin
		result = fval;
		carry_out = carry_in;
		case (sel)
			4'h0: result = ~fval;
			4'h1: result = fval - 8'h01;
			4'h2: result = fval + 8'h01;
			4'h3: result = acc | fval;
			4'h4: result = acc | lit;
			4'h5: result = acc;
			4'h6: result = lit;
			4'h7:
			begin
				result = {fval[6:0], carry_in};
				carry_out = fval[7];
			end
			4'h8:
			begin
				result = {carry_in, fval[7:1]};
				carry_out = fval[0];
			end
			default: result = fval;
		endcase
	end
endmodule

// [logic/boiex_core.sv]
// Decode and execute stage for a subset of a 12-bit instruction set.
// Assumes program memory presents the fetched word each cycle and the
// file register array answers reads combinationally.
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module boiex_core
	import boiex_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire logic CLK_EN,
	input wire logic [11:0] INSN,
	input wire logic [7:0] FILE_RDATA,
	input wire logic [7:0] STATUS_IN,
	input wire logic [10:0] STACK_TOP_ENTRY,
	output logic [4:0] FILE_ADDR,
	output logic FILE_WE,
	output logic [7:0] FILE_WDATA,
	output logic [7:0] ACC,
	output logic [7:0] PRESCALE_CFG,
	output logic ZERO_FLAG,
	output logic CARRY_FLAG,
	output logic [10:0] PC,
	output logic FLUSH,
	output logic STACK_POP
);
	////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {EXEC, BUBBLE} boiex_state_e;

	logic rst_s1_r;
	logic rst_n_r;
	boiex_state_e state_r;
	logic [7:0] acc_r;
	logic [7:0] cfg_r;
	logic zero_r;
	logic carry_r;
	logic [10:0] pc_r;
	logic [10:0] pc_nxt;
	logic [3:0] sel;
	logic [7:0] result;
	logic carry_res;
	logic is_file_op;
	logic dest_file;
	logic wr_acc;
	logic wr_file;
	logic set_zero;
	logic set_carry;
	logic skip;
	logic skip_op;
	logic take_jump;
	logic take_ret;
	logic valid;

	// Reset release through two flops
	always_ff @(posedge REF_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Decode; a discarded word executes as idle
	assign valid = (state_r == EXEC);
	assign dest_file = INSN[DEST_BIT];
	always_comb
	begin
		sel = 4'hf;
		is_file_op = 1'b0;
		wr_acc = 1'b0;
		wr_file = 1'b0;
		set_zero = 1'b0;
		set_carry = 1'b0;
		skip_op = 1'b0;
		take_jump = 1'b0;
		take_ret = 1'b0;
		if (valid)
		begin
			is_file_op = 1'b1;
			case (INSN[11:6])
				OP_COMPLEMENT: begin sel = 4'h0; set_zero = 1'b1; end
				OP_DECREMENT: begin sel = 4'h1; set_zero = 1'b1; end
				OP_DEC_SKIP: begin sel = 4'h1; skip_op = 1'b1; end
				OP_INCREMENT: begin sel = 4'h2; set_zero = 1'b1; end
				OP_INC_SKIP: begin sel = 4'h2; skip_op = 1'b1; end
				OP_OR_FILE: begin sel = 4'h3; set_zero = 1'b1; end
				OP_MOVE_FILE: begin sel = 4'hf; set_zero = 1'b1; end
				OP_ROT_LEFT: begin sel = 4'h7; set_carry = 1'b1; end
				OP_ROT_RIGHT: begin sel = 4'h8; set_carry = 1'b1; end
				default: is_file_op = 1'b0;
			endcase
			if (is_file_op)
			begin
				// Destination routing
				wr_file = dest_file;
				wr_acc = !dest_file;
			end
			else if (INSN[11:5] == OP_STORE_ACC)
			begin
				sel = 4'h5;
				wr_file = 1'b1;
			end
			else if (INSN[11:9] == OP_JUMP)
				take_jump = 1'b1;
			else if (INSN[11:8] == OP_OR_LIT)
			begin
				sel = 4'h4;
				wr_acc = 1'b1;
				set_zero = 1'b1;
			end
			else if (INSN[11:8] == OP_LOAD_LIT)
			begin
				sel = 4'h6;
				wr_acc = 1'b1;
			end
			else if (INSN[11:8] == OP_RET_LIT)
			begin
				sel = 4'h6;
				wr_acc = 1'b1;
				take_ret = 1'b1;
			end
		end
	end

	// Result unit
	boiex_alu u_alu (
		.sel(sel),
		.fval(FILE_RDATA),
		.acc(acc_r),
		.lit(INSN[7:0]),
		.carry_in(carry_r),
		.result(result),
		.carry_out(carry_res)
	);

	// Skip decision kept outside the decode process so the result path forms no loop
	assign skip = skip_op && (result == 8'h00);
	assign FILE_ADDR = INSN[4:0];
	assign FILE_WE = wr_file && CLK_EN;
	assign FILE_WDATA = result;
	assign FLUSH = valid && (skip || take_jump || take_ret);
	assign STACK_POP = take_ret && CLK_EN;

	////////////////////////////////////////////////////////////////////////
	// Two-cycle sequencing: flushed slot runs as idle
	always_ff @(posedge REF_CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
			state_r <= EXEC;
		else if (CLK_EN)
		begin
			case (state_r)
				EXEC: state_r <= FLUSH ? BUBBLE : EXEC;
				BUBBLE: state_r <= EXEC;
				default: state_r <= EXEC;
			endcase
		end
	end

	// Program counter
	always_comb
	begin
		pc_nxt = pc_r + 11'h001;
		if (take_jump)
			pc_nxt = {STATUS_IN[PAGE_HI:PAGE_LO], INSN[8:0]};
		else if (take_ret)
			pc_nxt = STACK_TOP_ENTRY;
	end
	always_ff @(posedge REF_CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
			pc_r <= PC_RST;
		else if (CLK_EN)
			pc_r <= pc_nxt;
	end

	// Accumulator
	always_ff @(posedge REF_CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
			acc_r <= ACC_RST;
		else if (CLK_EN && wr_acc)
			acc_r <= result;
	end

	// Prescaler configuration load
	always_ff @(posedge REF_CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
			cfg_r <= CFG_RST;
		else if (CLK_EN && valid && INSN == OP_PRESCALE)
			cfg_r <= acc_r;
	end

	// Zero and carry flags
	always_ff @(posedge REF_CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			zero_r <= 1'b0;
			carry_r <= 1'b0;
		end
		else if (CLK_EN)
		begin
			if (set_zero)
				zero_r <= (result == 8'h00);
			if (set_carry)
				carry_r <= carry_res;
		end
	end

	assign ACC = acc_r;
	assign PRESCALE_CFG = cfg_r;
	assign ZERO_FLAG = zero_r;
	assign CARRY_FLAG = carry_r;
	assign PC = pc_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!rst_n_r);

	zero_update_a: assert property (CLK_EN && set_zero |=> ZERO_FLAG == ($past(result) == 8'h00))
		else $error("zero flag wrong");
	skip_bubble_a: assert property (CLK_EN && valid && skip |=> !valid)
		else $error("skip did not insert idle");
	bubble_idle_a: assert property (!valid |-> !FILE_WE && !wr_acc && !set_zero)
		else $error("discarded word changed state");
	jump_target_a: assert property (CLK_EN && take_jump |=> PC == {$past(STATUS_IN[6:5]), $past(INSN[8:0])})
		else $error("jump target wrong");
	ret_load_a: assert property (CLK_EN && take_ret |=> ACC == $past(INSN[7:0]) && PC == $past(STACK_TOP_ENTRY))
		else $error("return wrong");
	dest_route_a: assert property (valid && is_file_op |-> FILE_WE == (dest_file && CLK_EN))
		else $error("destination routing wrong");
	store_acc_a: assert property (valid && INSN[11:5] == OP_STORE_ACC |-> FILE_WDATA == ACC && !set_zero)
		else $error("store accumulator wrong");
	cfg_load_a: assert property (CLK_EN && valid && INSN == OP_PRESCALE |=> PRESCALE_CFG == $past(ACC))
		else $error("prescaler load wrong");
	rot_carry_a: assert property (CLK_EN && valid && INSN[11:6] == OP_ROT_LEFT |=> CARRY_FLAG == $past(FILE_RDATA[7]))
		else $error("rotate carry wrong");
	skip_flags_a: assert property (valid && (INSN[11:6] == OP_INC_SKIP) |-> !set_zero && !set_carry)
		else $error("skip op touched flags");

	// Data path checks per operation
	complement_data_a: assert property (valid && INSN[11:6] == OP_COMPLEMENT
		|-> FILE_WDATA == ~FILE_RDATA && set_zero)
		else $error("complement result wrong");
	decrement_data_a: assert property (valid && INSN[11:6] == OP_DECREMENT
		|-> FILE_WDATA == FILE_RDATA - 8'h01 && set_zero)
		else $error("decrement result wrong");
	dec_skip_a: assert property (valid && INSN[11:6] == OP_DEC_SKIP
		|-> skip == (FILE_RDATA == 8'h01) && !set_zero && !set_carry)
		else $error("decrement skip wrong");
	increment_data_a: assert property (valid && INSN[11:6] == OP_INCREMENT
		|-> FILE_WDATA == FILE_RDATA + 8'h01 && set_zero)
		else $error("increment result wrong");
	inc_skip_a: assert property (valid && INSN[11:6] == OP_INC_SKIP
		|-> skip == (FILE_RDATA == 8'hff))
		else $error("increment skip wrong");
	or_file_a: assert property (valid && INSN[11:6] == OP_OR_FILE
		|-> FILE_WDATA == (ACC | FILE_RDATA) && set_zero)
		else $error("or with file wrong");
	move_file_a: assert property (valid && INSN[11:6] == OP_MOVE_FILE
		|-> FILE_WDATA == FILE_RDATA && set_zero)
		else $error("move file wrong");
	or_lit_a: assert property (CLK_EN && valid && INSN[11:8] == OP_OR_LIT
		|=> ACC == ($past(ACC) | $past(INSN[7:0])))
		else $error("or with literal wrong");
	load_lit_a: assert property (CLK_EN && valid && INSN[11:8] == OP_LOAD_LIT
		|=> ACC == $past(INSN[7:0]) && $stable(ZERO_FLAG) && $stable(CARRY_FLAG))
		else $error("load literal wrong");
	rot_right_a: assert property (CLK_EN && valid && INSN[11:6] == OP_ROT_RIGHT
		|=> CARRY_FLAG == $past(FILE_RDATA[0]))
		else $error("rotate right carry wrong");
	rotl_data_a: assert property (valid && INSN[11:6] == OP_ROT_LEFT
		|-> FILE_WDATA == {FILE_RDATA[6:0], CARRY_FLAG})
		else $error("rotate left data wrong");
	rotr_data_a: assert property (valid && INSN[11:6] == OP_ROT_RIGHT
		|-> FILE_WDATA == {CARRY_FLAG, FILE_RDATA[7:1]})
		else $error("rotate right data wrong");
	acc_dest_a: assert property (CLK_EN && valid && is_file_op && !dest_file
		|=> ACC == $past(FILE_WDATA))
		else $error("accumulator destination wrong");
	pc_step_a: assert property (rst_n_r && CLK_EN && !take_jump && !take_ret
		|=> PC == $past(PC) + 11'h001)
		else $error("program counter step wrong");

	skip_c: cover property (CLK_EN && valid && skip);
	rot_c: cover property (CLK_EN && set_carry);
	zero_set_c: cover property (CLK_EN && set_zero && result == 8'h00);
	jump_c: cover property (CLK_EN && take_jump);
	ret_c: cover property (CLK_EN && take_ret);
endmodule

// [verification/boiex_fmem.sv]
// File register model on the far side of the execute block.
// Assumes writes land on the rising edge while the write enable is high.
`timescale 1ns/1ps
module boiex_fmem
(
	input wire logic clk,
	input wire logic we,
	input wire logic [4:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] regs [32];
	// Combinational read of the addressed location
	assign rdata = regs[addr];
	// Write on the clock edge
	always_ff @(posedge clk)
	begin
		if (we)
			regs[addr] <= wdata;
	end
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the byte operation execute block.
// Assumes the file model answers reads in the same cycle.
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic en = 1'b1;
	logic [11:0] insn = 12'h000;
	logic [7:0] st = 8'h60;
	logic [10:0] stack_top_entry = 11'h123;
	logic [4:0] fa;
	logic fwe, z, c, fl, pop;
	logic [7:0] fwd, frd, acc, cfg;
	logic [10:0] pc;
	int errors = 0;
	int checks_done = 0;
	boiex_core dut (.REF_CLK(clk), .RSTN(rstn), .CLK_EN(en), .INSN(insn), .FILE_RDATA(frd), .STATUS_IN(st),
		.STACK_TOP_ENTRY(stack_top_entry), .FILE_ADDR(fa), .FILE_WE(fwe), .FILE_WDATA(fwd), .ACC(acc), .PRESCALE_CFG(cfg),
		.ZERO_FLAG(z), .CARRY_FLAG(c), .PC(pc), .FLUSH(fl), .STACK_POP(pop));
	boiex_fmem u_mem (.clk(clk), .we(fwe), .addr(fa), .wdata(fwd), .rdata(frd));
	////////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial
	begin
		forever #20 clk = ~clk;
	end
	initial
	begin
		#100000;
		errors++;
		finish_test();
	end
	////////////////////////////////////////////////////////////////
	// Report helpers
	task fail(input logic [10:0] g, input logic [10:0] e);
		errors++;
		$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
	endtask
	task chk_d(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e)
			fail({3'h0, g}, {3'h0, e});
	endtask
	task chk_b(input logic g, input logic e);
		checks_done++;
		if (g !== e)
			fail({10'h0, g}, {10'h0, e});
	endtask
	task chk_p(input logic [10:0] g, input logic [10:0] e);
		checks_done++;
		if (g !== e)
			fail(g, e);
	endtask
	task finish_test();
		$display("errors=%0d checks=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Instruction drivers
	// One word, then an idle word; results are settled on return
	task ex(input logic [11:0] w);
		@(posedge clk);
		insn <= w;
		@(posedge clk);
		insn <= 12'h000;
		#1;
	endtask
	// One word followed by a literal load that a flush must discard
	task sk(input logic [11:0] w, input logic f, input logic we, input logic [10:0] p);
		@(posedge clk);
		insn <= w;
		#1;
		chk_b(fl, f);
		chk_b(fwe, we);
		chk_b(pop, w[11:8] == 4'h8);
		@(posedge clk);
		insn <= 12'hc77;
		#1;
		if (p != 11'h000)
			chk_p(pc, p);
		@(posedge clk);
		insn <= 12'h000;
		#1;
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		#1;
		// Internal reset copy is still low here
		chk_d(acc, 8'h00);
		chk_d(cfg, 8'hff);
		chk_p(pc, 11'h7ff);
		chk_b(z, 1'b0);
		chk_b(c, 1'b0);
		repeat (4) @(posedge clk);
		ex(12'hc5a);
		chk_d(acc, 8'h5a);
		chk_b(z, 1'b0);
		ex(12'h025);
		chk_d(u_mem.regs[5], 8'h5a);
		ex(12'h245);
		chk_d(acc, 8'ha5);
		chk_d(u_mem.regs[5], 8'h5a);
		ex(12'h265);
		chk_d(u_mem.regs[5], 8'ha5);
		ex(12'hcff);
		ex(12'h026);
		ex(12'h2a6);
		chk_d(u_mem.regs[6], 8'h00);
		chk_b(z, 1'b1);
		ex(12'h0c6);
		chk_d(acc, 8'hff);
		chk_b(z, 1'b0);
		ex(12'hc00);
		ex(12'hd00);
		chk_b(z, 1'b1);
		ex(12'hd35);
		chk_d(acc, 8'h35);
		chk_b(z, 1'b0);
		ex(12'h105);
		chk_d(acc, 8'hb5);
		ex(12'h226);
		chk_b(z, 1'b1);
		ex(12'h002);
		chk_d(cfg, 8'hb5);
		chk_b(z, 1'b1);
		ex(12'hce6);
		ex(12'h027);
		ex(12'h347);
		chk_d(acc, 8'hcc);
		chk_b(c, 1'b1);
		ex(12'h327);
		chk_d(u_mem.regs[7], 8'hf3);
		chk_b(c, 1'b0);
		ex(12'h000);
		chk_d(acc, 8'hcc);
		chk_b(z, 1'b1);
		ex(12'hc00);
		ex(12'hd01);
		ex(12'h028);
		sk(12'h2e8, 1'b1, 1'b1, 11'h000);
		chk_d(acc, 8'h01);
		chk_b(z, 1'b0);
		chk_d(u_mem.regs[8], 8'h00);
		sk(12'h2c8, 1'b0, 1'b0, 11'h000);
		chk_d(acc, 8'h77);
		ex(12'hcff);
		ex(12'h028);
		sk(12'h3e8, 1'b1, 1'b1, 11'h000);
		chk_d(acc, 8'hff);
		chk_b(z, 1'b0);
		sk(12'hba5, 1'b1, 1'b0, 11'h7a5);
		chk_d(acc, 8'hff);
		chk_b(c, 1'b0);
		sk(12'h842, 1'b1, 1'b0, 11'h123);
		chk_d(acc, 8'h42);
		// Frozen clock enable holds every register and blocks file writes
		@(posedge clk);
		en <= 1'b0;
		ex(12'hc11);
		ex(12'h025);
		chk_d(acc, 8'h42);
		chk_d(u_mem.regs[5], 8'ha5);
		chk_p(pc, 11'h125);
		@(posedge clk);
		en <= 1'b1;
		finish_test();
	end
endmodule
